// ===== verilog/memory_card_strobe_and_datapath.sv
// Overview of operation
// - strobe sequencing follows edo dram timing
// - four way everywhere, two way bank0 card0
// - two way 32 MB; four way 64MB..8GB
// - up to eight banks over two cards
// - each bank holds up to 1 GB
// - bank has one or two rows
// - one row strobe per row
// - interleave word is 64 data plus 8 check
// - four interleaves make one 32-byte line
// - 72-bit exchange, one line per 30 ns; four 8 ns beats here take 32 ns
// - generator idle until a command arrives
// - at most two generators, four banks each
// - single-sided one row, double-sided two rows
// - four independent strobe units, one per bank
// - mux has four dram ports, one bus port
// - two muxes side by side form 72 bits
// - 16 or 64 Mbit, single/double high modules
// - reset clears all; controller then refreshes eight
// - all four banks share slowest timing
`timescale 1ns/1ps
`default_nettype none
module memory_card_strobe_and_datapath
  import memory_card_pkg::*;
#(
  parameter logic       CARD_INDEX = 1'b0,
  parameter int         BANKS      = BANKS_PER_GENERATOR,
  parameter logic [3:0] RAS_TO_CAS = RAS_TO_CAS_CYCLES,
  parameter logic [3:0] PRECHARGE  = PRECHARGE_CYCLES
) (
  // clock and reset
  input  wire logic                                 clk_sys,
  input  wire logic                                 rst,
  // command from the controller
  input  wire mem_request_t                         request,
  // dram strobes
  output bank_strobes_t [BANKS-1:0]                 bank_strobes,
  // dram data, one 72-bit word per interleave
  input  wire logic [INTERLEAVES_MAX-1:0][WORD_BITS-1:0] dram_rd,
  output logic      [INTERLEAVES_MAX-1:0][WORD_BITS-1:0] dram_wr,
  output logic      [INTERLEAVES_MAX-1:0]                dram_oe,
  // memory data bus toward the controller
  input  wire logic [WORD_BITS-1:0]                 bus_wr,
  output logic      [WORD_BITS-1:0]                 bus_rd,
  output logic                                      bus_valid,
  // status
  output logic                                      request_accepted,
  output logic                                      request_refused,
  output logic [BANKS-1:0]                          bank_busy
);

  // a slot holds the data phase sequencing for one access
  typedef struct packed {
    logic                    active;
    logic                    write;
    logic [1:0]              bank;
    logic [1:0]              beat;
    logic [1:0]              last_beat;
    logic                    capture;
    logic                    capture_d;
    logic                    accepted;
    logic                    refused;
    logic [BANKS-1:0]        busy;
    logic                    valid_out;
  } top_state_t;

  top_state_t state;
  top_state_t next_state;

  logic [BANKS-1:0]          unit_start;
  logic [BANKS-1:0]          unit_busy;
  logic [BANKS-1:0]          unit_done;
  bank_strobes_t [BANKS-1:0] unit_strobes;
  logic                      config_ok;
  logic                      is_access;
  logic [1:0]                mux_select;
  logic [HALF_WORD_BITS-1:0] mux_rd_lo;
  logic [HALF_WORD_BITS-1:0] mux_rd_hi;
  logic [INTERLEAVES_MAX-1:0][HALF_WORD_BITS-1:0] rd_lo;
  logic [INTERLEAVES_MAX-1:0][HALF_WORD_BITS-1:0] rd_hi;
  logic [INTERLEAVES_MAX-1:0][HALF_WORD_BITS-1:0] wr_lo;
  logic [INTERLEAVES_MAX-1:0][HALF_WORD_BITS-1:0] wr_hi;
  logic [INTERLEAVES_MAX-1:0]                     oe_lo;
  logic [INTERLEAVES_MAX-1:0]                     oe_hi;

  // two way interleave is legal only on the first bank of the first card
  function automatic logic interleave_legal(input logic four_way, input logic [1:0] bank);
    interleave_legal = four_way || (bank == 2'h0 && CARD_INDEX == 1'b0);
  endfunction : interleave_legal

  assign config_ok = interleave_legal(request.four_way, request.bank);
  assign is_access = request.valid && (request.op == CMD_READ || request.op == CMD_WRITE);

  // command routing: only the addressed unit sees the start, and only when idle
  generate
    for (genvar b = 0; b < BANKS; b++) begin : g_unit
      assign unit_start[b] = request.valid && request.op != CMD_NONE && config_ok
                             && request.bank == 2'(b) && !unit_busy[b]
                             && !(is_access && state.active);

      // every unit gets the same timing, set for the slowest module
      bank_strobe_control_unit u_unit (
        .clk_sys    (clk_sys),
        .rst        (rst),
        .start      (unit_start[b]),
        .op         (request.op),
        .row        (request.row),
        .ras_to_cas (RAS_TO_CAS),
        .precharge  (PRECHARGE),
        .busy       (unit_busy[b]),
        .cycle_done (unit_done[b]),
        .strobes    (unit_strobes[b])
      );
    end
  endgenerate

  // split each 72-bit interleave word into the halves the two muxes carry
  generate
    for (genvar i = 0; i < INTERLEAVES_MAX; i++) begin : g_split
      assign rd_lo[i] = dram_rd[i][HALF_WORD_BITS-1:0];
      assign rd_hi[i] = dram_rd[i][WORD_BITS-1:HALF_WORD_BITS];
      assign dram_wr[i] = {wr_hi[i], wr_lo[i]};
    end
  endgenerate

  assign dram_oe    = oe_lo | oe_hi;
  assign mux_select = state.beat;

  // low and high halves side by side form the 72-bit path
  interleave_data_mux #(.PORT_BITS(HALF_WORD_BITS)) u_mux_lo (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .select    (mux_select),
    .write_dir (state.write),
    .capture   (state.capture),
    .dram_rd   (rd_lo),
    .dram_wr   (wr_lo),
    .dram_oe   (oe_lo),
    .bus_wr    (bus_wr[HALF_WORD_BITS-1:0]),
    .bus_rd    (mux_rd_lo)
  );

  interleave_data_mux #(.PORT_BITS(HALF_WORD_BITS)) u_mux_hi (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .select    (mux_select),
    .write_dir (state.write),
    .capture   (state.capture),
    .dram_rd   (rd_hi),
    .dram_wr   (wr_hi),
    .dram_oe   (oe_hi),
    .bus_wr    (bus_wr[WORD_BITS-1:HALF_WORD_BITS]),
    .bus_rd    (mux_rd_hi)
  );

  assign bus_rd = {mux_rd_hi, mux_rd_lo};

  // data phase: after the strobe unit finishes, walk the interleaves one per cycle;
  // four beats of 72 bits move one 32-byte line in 32 ns, over the 30 ns line time
  always_comb begin
    next_state           = state;
    next_state.accepted  = |unit_start;
    next_state.refused   = request.valid && request.op != CMD_NONE && !(|unit_start);
    next_state.busy      = unit_busy | unit_start;
    next_state.capture_d = state.capture;
    next_state.valid_out = state.capture_d && !state.write;
    if (is_access && (|unit_start)) begin
      next_state.active    = 1'b1;
      next_state.write     = (request.op == CMD_WRITE);
      next_state.bank      = request.bank;
      next_state.beat      = 2'h0;
      next_state.last_beat = request.four_way ? 2'h3 : 2'h1;
      next_state.capture   = 1'b0;
    end else if (state.active) begin
      if (!state.capture) begin
        // only the addressed unit may open the data phase; a refresh elsewhere must not
        if (unit_done[state.bank]) begin
          next_state.capture = 1'b1;
        end
      end else if (state.beat == state.last_beat) begin
        next_state.capture = 1'b0;
        next_state.active  = 1'b0;
      end else begin
        next_state.beat = state.beat + 2'h1;
      end
    end
  end

  // sequencing state is dropped on memory reset
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign bank_strobes     = unit_strobes;
  assign bus_valid        = state.valid_out;
  assign request_accepted = state.accepted;
  assign request_refused  = state.refused;
  assign bank_busy        = state.busy;

endmodule : memory_card_strobe_and_datapath
`default_nettype wire

// ===== shared/memory_card_pkg.sv
package memory_card_pkg;

  // organisation of one card
  localparam int BANKS_PER_GENERATOR = 4;
  localparam int ROWS_PER_BANK       = 2;
  localparam int INTERLEAVES_MAX     = 4;
  localparam int MAX_GENERATORS      = 2;
  localparam int MAX_BANKS_TOTAL     = 8;
  localparam int WORD_BITS           = 72;
  localparam int DATA_BITS           = 64;
  localparam int ECC_BITS            = 8;
  localparam int HALF_WORD_BITS      = 36;
  localparam int LINE_DATA_BITS      = 256;
  localparam int LINE_BYTES          = 32;
  localparam int REFRESH_PER_BANK    = 8;

  // sizes in megabytes
  localparam int SIZE_2WAY_MB        = 32;
  localparam int SIZE_STEP_MB        = 64;
  localparam int SIZE_MAX_MB         = 8192;
  localparam int BANK_MAX_MB         = 1024;

  // clock and line rate
  localparam int CLK_PERIOD_PS       = 8000;
  localparam int LINE_TIME_PS        = 30000;
  localparam int LINE_CYCLES         = LINE_TIME_PS / CLK_PERIOD_PS;

  // edo strobe timing in cycles
  localparam logic [3:0] RAS_TO_CAS_CYCLES = 4'h2;
  localparam logic [3:0] CAS_PULSE_CYCLES  = 4'h1;
  localparam logic [3:0] PRECHARGE_CYCLES  = 4'h3;

  // command opcodes from the controller
  typedef enum logic [1:0] {
    CMD_NONE    = 2'h0,
    CMD_READ    = 2'h1,
    CMD_WRITE   = 2'h2,
    CMD_REFRESH = 2'h3
  } mem_cmd_t;

  typedef struct packed {
    logic       valid;
    mem_cmd_t   op;
    logic [1:0] bank;
    logic       row;
    logic       four_way;
  } mem_request_t;

  // strobe unit phases, gray along the access path
  typedef enum logic [2:0] {
    UNIT_IDLE  = 3'b000,
    UNIT_RAS   = 3'b001,
    UNIT_CAS   = 3'b011,
    UNIT_PRECH = 3'b010,
    UNIT_CBR   = 3'b110
  } unit_phase_t;

  typedef struct packed {
    logic [ROWS_PER_BANK-1:0] ras;
    logic                     cas;
    logic                     we;
  } bank_strobes_t;

endpackage : memory_card_pkg

// ===== verilog/bank_strobe_control_unit.sv
`timescale 1ns/1ps
`default_nettype none
module bank_strobe_control_unit
  import memory_card_pkg::*;
(
  // clock and reset
  input  wire logic          clk_sys,
  input  wire logic          rst,
  // command for this bank
  input  wire logic          start,
  input  wire mem_cmd_t      op,
  input  wire logic          row,
  // shared timing
  input  wire logic [3:0]    ras_to_cas,
  input  wire logic [3:0]    precharge,
  // status and strobes
  output logic               busy,
  output logic               cycle_done,
  output bank_strobes_t      strobes
);

  typedef struct packed {
    unit_phase_t   phase;
    logic [3:0]    count;
    bank_strobes_t strobes;
    logic          done;
  } unit_state_t;

  unit_state_t state;
  unit_state_t next_state;

  // one phase machine per bank; strobes are registered so no glitches reach the dram
  always_comb begin
    next_state      = state;
    next_state.done = 1'b0;
    case (state.phase)
      UNIT_IDLE: begin
        if (start && op != CMD_NONE) begin
          next_state.count = ras_to_cas;
          if (op == CMD_REFRESH) begin
            // cas before ras refreshes both rows at once
            next_state.phase       = UNIT_CBR;
            next_state.strobes.cas = 1'b1;
          end else begin
            next_state.phase            = UNIT_RAS;
            next_state.strobes.ras[row] = 1'b1;
            next_state.strobes.we       = (op == CMD_WRITE);
          end
        end
      end
      UNIT_RAS: begin
        if (state.count <= 4'h1) begin
          next_state.phase       = UNIT_CAS;
          next_state.count       = CAS_PULSE_CYCLES;
          next_state.strobes.cas = 1'b1;
        end else begin
          next_state.count = state.count - 4'h1;
        end
      end
      UNIT_CBR: begin
        if (state.count <= 4'h1) begin
          next_state.phase       = UNIT_CAS;
          next_state.count       = CAS_PULSE_CYCLES;
          next_state.strobes.ras = '1;
        end else begin
          next_state.count = state.count - 4'h1;
        end
      end
      UNIT_CAS: begin
        if (state.count <= 4'h1) begin
          next_state.phase   = UNIT_PRECH;
          next_state.count   = precharge;
          next_state.strobes = '0;
        end else begin
          next_state.count = state.count - 4'h1;
        end
      end
      UNIT_PRECH: begin
        if (state.count <= 4'h1) begin
          next_state.phase = UNIT_IDLE;
          next_state.done  = 1'b1;
        end else begin
          next_state.count = state.count - 4'h1;
        end
      end
      default: begin
        next_state = '0;
      end
    endcase
  end

  // reset clears any access in flight
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign busy       = (state.phase != UNIT_IDLE);
  assign cycle_done = state.done;
  assign strobes    = state.strobes;

endmodule : bank_strobe_control_unit
`default_nettype wire

// ===== verilog/interleave_data_mux.sv
`timescale 1ns/1ps
`default_nettype none
module interleave_data_mux
  import memory_card_pkg::*;
#(
  parameter int PORT_BITS = HALF_WORD_BITS
) (
  // clock and reset
  input  wire logic                                  clk_sys,
  input  wire logic                                  rst,
  // steering
  input  wire logic [1:0]                            select,
  input  wire logic                                  write_dir,
  input  wire logic                                  capture,
  // dram side, one port per interleaved quad-word
  input  wire logic [INTERLEAVES_MAX-1:0][PORT_BITS-1:0] dram_rd,
  output logic      [INTERLEAVES_MAX-1:0][PORT_BITS-1:0] dram_wr,
  output logic      [INTERLEAVES_MAX-1:0]                dram_oe,
  // memory data bus side
  input  wire logic [PORT_BITS-1:0]                  bus_wr,
  output logic      [PORT_BITS-1:0]                  bus_rd
);

  typedef struct packed {
    logic [INTERLEAVES_MAX-1:0][PORT_BITS-1:0] wr;
    logic [INTERLEAVES_MAX-1:0]                oe;
    logic [PORT_BITS-1:0]                      rd;
  } mux_state_t;

  mux_state_t state;
  mux_state_t next_state;

  // one selected interleave moves per capture; latches hold between them
  always_comb begin
    next_state    = state;
    next_state.oe = '0;
    if (capture) begin
      if (write_dir) begin
        next_state.wr[select] = bus_wr;
        next_state.oe[select] = 1'b1;
      end else begin
        next_state.rd = dram_rd[select];
      end
    end
  end

  // buffers are emptied on memory reset
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign dram_wr = state.wr;
  assign dram_oe = state.oe;
  assign bus_rd  = state.rd;

endmodule : interleave_data_mux
`default_nettype wire

// ===== bench/memory_card_chk.sv
`timescale 1ns/1ps
`default_nettype none
module memory_card_chk
  import memory_card_pkg::*;
#(
  parameter int BANKS = BANKS_PER_GENERATOR
) (
  // clock and reset
  input wire logic                      clk_sys,
  input wire logic                      rst,
  // watched ports
  input wire mem_request_t              request,
  input wire bank_strobes_t [BANKS-1:0] bank_strobes,
  input wire logic                      bus_valid,
  input wire logic                      request_accepted,
  input wire logic                      request_refused,
  input wire logic [BANKS-1:0]          bank_busy
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  // a read answered one edge after it was taken
  sequence took_read;
    request_accepted && $past(request.op) == CMD_READ;
  endsequence
  // four beats of one line, back to back
  sequence read_beats;
    bus_valid [*4];
  endsequence

  a_one_answer: assert property (!(request_accepted && request_refused)) else $error("accept and refuse together");
  a_idle_quiet: assert property (!$past(request.valid) |-> !request_accepted)
    else $error("accept without a request");
  a_row_strobe: assert property (took_read |-> bank_strobes[$past(request.bank)].ras[$past(request.row)])
    else $error("row strobe missing");
  a_cas_follow: assert property (took_read |-> ##2 bank_strobes[$past(request.bank, 3)].cas
    ##1 !bank_strobes[$past(request.bank, 4)].cas) else $error("column strobe timing");
  a_busy_set: assert property (request_accepted |-> bank_busy[$past(request.bank)])
    else $error("unit not busy");
  a_bad_interleave: assert property ($past(request.valid && request.op != CMD_NONE
    && !request.four_way && request.bank != 2'h0) |-> request_refused) else $error("two way not refused");
  a_read_stream: assert property (took_read ##0 $past(request.four_way) |-> ##9 read_beats)
    else $error("line beats late");
  a_refresh_cas: assert property (request_accepted && $past(request.op) == CMD_REFRESH
    |-> bank_strobes[$past(request.bank)].cas && bank_strobes[$past(request.bank)].ras == '0)
    else $error("refresh not cas first");
  a_refuse_quiet: assert property (request_refused |-> (bank_busy & ~$past(bank_busy)) == '0)
    else $error("refused request started");
  a_write_strobe: assert property (request_accepted && $past(request.op) == CMD_WRITE
    |-> bank_strobes[$past(request.bank)].we) else $error("write strobe missing");
endmodule : memory_card_chk

bind memory_card_strobe_and_datapath memory_card_chk #(.BANKS(BANKS)) u_chk (
  .clk_sys(clk_sys), .rst(rst), .request(request), .bank_strobes(bank_strobes), .bus_valid(bus_valid),
  .request_accepted(request_accepted), .request_refused(request_refused), .bank_busy(bank_busy));
`default_nettype wire

// ===== bench/controller_model.sv
`timescale 1ns/1ps
`default_nettype none
module controller_model
  import memory_card_pkg::*;
(
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // design answers
  input  wire logic       request_accepted,
  input  wire logic [3:0] bank_busy,
  // commands
  output mem_request_t    request,
  output logic            init_done
);
  int bank;
  int n;
  int k;
  // wake-up refresh burst; a refused one is retried once the unit idles
  initial begin
    request = '0;
    init_done = 1'b0;
    @(negedge rst);
    for (bank = 0; bank < 4; bank++) begin
      for (n = 0; n < REFRESH_PER_BANK; n++) begin
        @(negedge clk_sys);
        request <= '{1'b1, CMD_REFRESH, 2'(bank), 1'b0, 1'b1};
        @(negedge clk_sys);
        request <= '0;
        // the answer stands for one cycle only, so it is read before the next edge
        if (!request_accepted) n--;
        for (k = 0; k < 40 && bank_busy[bank]; k++) @(negedge clk_sys);
      end
    end
    init_done = 1'b1;
  end
endmodule : controller_model
`default_nettype wire

// ===== bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import memory_card_pkg::*;
  typedef struct packed {
    mem_request_t req;
    logic         acc;
    logic [2:0]   n;
  } row_t;
  // stimulus
  logic                                      clk_sys;
  logic                                      rst;
  mem_request_t                              tb_req;
  mem_request_t                              ctl_req;
  mem_request_t                              request;
  logic                                      init_done;
  logic [INTERLEAVES_MAX-1:0][WORD_BITS-1:0] dram_rd;
  logic [WORD_BITS-1:0]                      bus_wr;
  // design outputs
  bank_strobes_t [3:0]                       bank_strobes;
  logic [INTERLEAVES_MAX-1:0][WORD_BITS-1:0] dram_wr;
  logic [INTERLEAVES_MAX-1:0]                dram_oe;
  logic [WORD_BITS-1:0]                      bus_rd;
  logic [WORD_BITS-1:0]                      prev_rd;
  logic                                      bus_valid;
  logic                                      request_accepted;
  logic                                      request_refused;
  logic [3:0]                                bank_busy;
  logic                                      acc;
  logic                                      ref_seen;
  int                                        err_total;
  int                                        cmp_count;
  int                                        i;
  int                                        beats;
  int                                        oes;
  row_t                                      rows [7];

  // the model owns the bus until its refresh burst is over
  assign request = init_done ? tb_req : ctl_req;

  memory_card_strobe_and_datapath u_memory_card_strobe_and_datapath (
    .clk_sys(clk_sys), .rst(rst), .request(request), .bank_strobes(bank_strobes), .dram_rd(dram_rd),
    .dram_wr(dram_wr), .dram_oe(dram_oe), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_valid(bus_valid),
    .request_accepted(request_accepted), .request_refused(request_refused), .bank_busy(bank_busy));
  controller_model u_controller_model (
    .clk_sys(clk_sys), .rst(rst), .request_accepted(request_accepted), .bank_busy(bank_busy),
    .request(ctl_req), .init_done(init_done));

  function automatic mem_request_t mk(input mem_cmd_t op, input logic [1:0] b, input logic r, input logic fw);
    return '{1'b1, op, b, r, fw};
  endfunction : mk

  task automatic check(input logic ok, input string what);
    cmp_count++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("mismatch at %0t: %s", $time, what);
    end
  endtask : check

  // one-cycle request, answer sampled one edge after the take
  task automatic send(input mem_request_t r);
    @(negedge clk_sys);
    tb_req = r;
    @(negedge clk_sys);
    acc = request_accepted;
    ref_seen = request_refused;
    tb_req = '0;
  endtask : send

  // valid flags the word that stood on the bus one cycle earlier
  task automatic watch(output int nb, output int no);
    nb = 0;
    no = 0;
    repeat (24) begin
      if (bus_valid === 1'b1) begin
        check(prev_rd === dram_rd[nb[1:0]], "read word");
        nb++;
      end
      for (int k = 0; k < 4; k++)
        if (dram_oe[k] === 1'b1) begin
          check(dram_wr[k] === bus_wr, "write word");
          no++;
        end
      prev_rd = bus_rd;
      @(negedge clk_sys);
    end
  endtask : watch

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // a hang costs a mismatch; the tests need well under 5000 cycles
  initial begin
    #200us;
    err_total++;
    wrap_up();
  end

  initial begin
    rst = 1'b1;
    tb_req = '0;
    bus_wr = 72'hc3_0f1e_2d3c_4b5a_6978;
    prev_rd = '0;
    err_total = 0;
    cmp_count = 0;
    for (i = 0; i < 4; i++) dram_rd[i] = {8'ha0 + 8'(i), {8{8'h05 + 8'(i)}}};
    rows[0] = '{mk(CMD_READ, 2'h0, 1'b0, 1'b1), 1'b1, 3'h4};
    rows[1] = '{mk(CMD_WRITE, 2'h1, 1'b1, 1'b1), 1'b1, 3'h4};
    rows[2] = '{mk(CMD_REFRESH, 2'h2, 1'b0, 1'b1), 1'b1, 3'h0};
    rows[3] = '{mk(CMD_READ, 2'h3, 1'b1, 1'b0), 1'b0, 3'h0};
    rows[4] = '{mk(CMD_READ, 2'h0, 1'b1, 1'b0), 1'b1, 3'h2};
    rows[5] = '{mk(CMD_WRITE, 2'h0, 1'b0, 1'b0), 1'b1, 3'h2};
    rows[6] = '{mk(CMD_REFRESH, 2'h1, 1'b0, 1'b0), 1'b0, 3'h0};
    repeat (10) @(posedge clk_sys);
    @(negedge clk_sys);
    rst = 1'b0;
    check(bank_strobes === '0 && bus_valid === 1'b0 && bank_busy === 4'h0, "reset state");
    for (i = 0; i < 3000 && init_done !== 1'b1; i++) @(negedge clk_sys);
    check(init_done === 1'b1, "refresh burst");
    // table of ordinary commands
    for (i = 0; i < 7; i++) begin
      send(rows[i].req);
      check(acc === rows[i].acc && ref_seen === !rows[i].acc, "answer");
      watch(beats, oes);
      check(beats + oes == int'(rows[i].n), "beat count");
    end
    // same bank twice in a row: the second is refused
    @(negedge clk_sys);
    tb_req = mk(CMD_READ, 2'h1, 1'b0, 1'b1);
    @(negedge clk_sys);
    check(request_accepted === 1'b1, "first taken");
    @(negedge clk_sys);
    tb_req = '0;
    check(request_refused === 1'b1, "busy bank refused");
    watch(beats, oes);
    check(beats == 4 && oes == 0, "line after refusal");
    // other banks on consecutive edges are both taken
    tb_req = mk(CMD_REFRESH, 2'h2, 1'b0, 1'b1);
    @(negedge clk_sys);
    check(request_accepted === 1'b1, "bank two taken");
    tb_req = mk(CMD_REFRESH, 2'h3, 1'b1, 1'b1);
    @(negedge clk_sys);
    tb_req = '0;
    check(request_accepted === 1'b1 && bank_busy === 4'hc, "bank three taken");
    watch(beats, oes);
    check(beats + oes == 0, "refresh moves no data");
    // reset in the middle of a read drops everything
    send(mk(CMD_READ, 2'h0, 1'b0, 1'b1));
    rst = 1'b1;
    @(negedge clk_sys);
    rst = 1'b0;
    check(bank_busy === 4'h0 && bank_strobes === '0 && bus_valid === 1'b0, "mid reset");
    watch(beats, oes);
    check(beats + oes == 0, "no data after reset");
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
